// ===== dv/psr_host_monitor.sv
`timescale 1ns/1ns
// ==========
// host pin sequencing checks
module psr_host_monitor #(
  parameter int ADDR_W = 13
) (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              reqValid,
  input wire logic              reqReady,
  input wire logic              reqWrite,
  input wire logic              rspValid,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic              chipSel_b,
  input wire logic              writeEn_b,
  input wire logic              outEn_b,
  input wire logic              parity_func_enable_n,
  input wire logic              byte_data_lines_oe,
  input wire logic              ninth_data_line_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  take_busy_a: assert property (reqValid && reqReady |=> !reqReady)
    else $error("ready stayed high after take");
  write_lat_a: assert property (reqValid && reqReady && reqWrite |-> ##9 rspValid)
    else $error("write answer late");
  read_lat_a: assert property (reqValid && reqReady && !reqWrite |-> ##7 rspValid)
    else $error("read answer late");
  addr_hold_a: assert property (!chipSel_b && !writeEn_b |-> $stable(word_address))
    else $error("address moved in write");
  we_pulse_a: assert property ($fell(writeEn_b) |-> !writeEn_b [*6] ##1 writeEn_b)
    else $error("write pulse width wrong");
  bus_drive_a: assert property (byte_data_lines_oe |-> !chipSel_b && outEn_b)
    else $error("host drives bus outside write");
  ninth_drive_a: assert property (ninth_data_line_oe |-> parity_func_enable_n)
    else $error("host drives ninth line in parity mode");
  read_pins_a: assert property (!outEn_b |-> !chipSel_b && writeEn_b)
    else $error("output enable outside read");
  end_idle_a: assert property (rspValid |-> chipSel_b && writeEn_b && !byte_data_lines_oe)
    else $error("strobes active at answer");
  pe_fixed_a: assert property (!chipSel_b |-> $stable(parity_func_enable_n))
    else $error("parity enable moved in access");
  cover property (reqValid && reqReady && reqWrite);
  cover property (reqValid && reqReady && !reqWrite);
  cover property (ninth_data_line_oe);
endmodule
bind psr_host_ctrl psr_host_monitor #(.ADDR_W(ADDR_W)) mon_u (.core_clk, .rst_b, .reqValid,
  .reqReady, .reqWrite, .rspValid, .word_address, .chipSel_b, .writeEn_b, .outEn_b,
  .parity_func_enable_n, .byte_data_lines_oe, .ninth_data_line_oe);

// ===== dv/psr_sram_model.sv
`timescale 1ns/1ns
// ==========
// far-side parity memory
module psr_sram_model #(
  parameter bit ODD = 1'b0
) (
  input  wire logic [12:0] word_address,
  input  wire logic        chipSel_b,
  input  wire logic        writeEn_b,
  input  wire logic        outEn_b,
  input  wire logic        parity_func_enable_n,
  input  wire logic [7:0]  byteIn,
  input  wire logic        ninthIn,
  output logic [7:0]       byteOut,
  output logic             byteOe,
  output logic             ninthOut,
  output logic             ninthOe
);
  logic [8:0] mem [0:8191];
  logic [8:0] word;
  logic       rdOn;
  assign word = mem[word_address];
  assign rdOn = !chipSel_b && writeEn_b && !outEn_b;
  assign byteOe = rdOn;
  assign byteOut = word[7:0];
  assign ninthOut = parity_func_enable_n ? word[8] : 1'b0;
  assign ninthOe = rdOn && (parity_func_enable_n || word[8] != (^word[7:0] ^ ODD));
  // write lands at whichever strobe rises first
  always @(posedge writeEn_b or posedge chipSel_b)
    if (!(chipSel_b && writeEn_b))
      mem[word_address] <= {parity_func_enable_n ? ninthIn : ^byteIn ^ ODD, byteIn};
endmodule

// ===== dv/test_parity_sram_8k_x9.sv
`timescale 1ns/1ns
// ==========
// bench
module test_parity_sram_8k_x9;
  localparam bit ODD = 1'b0;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic        reqParity = 1'b0;
  logic [12:0] reqAddr = 13'h0000;
  logic [8:0]  reqData = 9'h000;
  logic [8:0]  rspData;
  logic [12:0] word_address;
  logic [7:0]  byteBus, hostB, memB;
  logic [7:0]  lastByte = 8'h00;
  logic        reqReady, rspValid, rspParityFault, chipSel_b, writeEn_b, outEn_b, peN;
  logic        hostOe, hostN, hostNOe, memOe, memN, memNOe, ninthBus;
  int          mismatches = 0;
  int          cmp_count = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) lastByte <= byteBus;
  // released bus shows a moving value, ninth line is pulled up
  assign byteBus = (hostOe === 1'b1) ? hostB : ((memOe === 1'b1) ? memB : ~lastByte);
  assign ninthBus = !((hostNOe && !hostN) || (memNOe && !memN));
  psr_host_ctrl dut_u (.core_clk, .rst_b, .reqValid, .reqWrite, .reqParity, .reqAddr, .reqData,
    .reqReady, .rspValid, .rspData, .rspParityFault, .word_address, .chipSel_b, .writeEn_b,
    .outEn_b, .parity_func_enable_n(peN), .byte_data_lines_i(byteBus),
    .byte_data_lines_o(hostB), .byte_data_lines_oe(hostOe), .ninth_data_line_i(ninthBus),
    .ninth_data_line_o(hostN), .ninth_data_line_oe(hostNOe));
  psr_sram_model #(.ODD(ODD)) model_u (.word_address, .chipSel_b, .writeEn_b, .outEn_b,
    .parity_func_enable_n(peN), .byteIn(byteBus), .ninthIn(ninthBus), .byteOut(memB),
    .byteOe(memOe), .ninthOut(memN), .ninthOe(memNOe));
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input logic w, input logic p, input logic [12:0] a, input logic [8:0] d, input int lat);
    int n;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqParity <= p;
    reqAddr <= a;
    reqData <= d;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (reqReady !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, reqReady, 1'b1);
      mismatches++;
      summarize();
    end
    @(posedge core_clk);
    reqValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, rspValid, 1'b1);
      mismatches++;
      summarize();
    end
    chk(9'(n), 9'(lat));
  endtask
  task t_reset;
    chk({5'h00, reqReady, chipSel_b, writeEn_b, outEn_b}, 9'h00F);
    chk({5'h00, rspValid, hostOe, hostNOe, peN}, 9'h001);
    chk(rspData, 9'h000);
    chk({8'h00, rspParityFault}, 9'h000);
    $display("reset test done");
  endtask
  task t_plain;
    op(1'b1, 1'b0, 13'h1FFF, 9'h1A5, 9);
    op(1'b0, 1'b0, 13'h1FFF, 9'h000, 7);
    chk(rspData, 9'h1A5);
    chk({8'h00, rspParityFault}, 9'h000);
    $display("plain test done");
  endtask
  task t_gen(input logic [7:0] d);
    op(1'b1, 1'b1, 13'h0001, {1'b0, d}, 9);
    op(1'b0, 1'b0, 13'h0001, 9'h000, 7);
    chk(rspData, {^d ^ ODD, d});
    op(1'b0, 1'b1, 13'h0001, 9'h000, 7);
    chk(rspData, {1'b0, d});
    chk({8'h00, rspParityFault}, 9'h000);
    $display("generate test done");
  endtask
  task t_force(input logic bad);
    op(1'b1, 1'b0, 13'h0AAA, {bad ^ ^8'h5A ^ ODD, 8'h5A}, 9);
    op(1'b0, 1'b1, 13'h0AAA, 9'h000, 7);
    chk({8'h00, rspParityFault}, {8'h00, bad});
    op(1'b0, 1'b0, 13'h1FFF, 9'h000, 7);
    chk(rspData, 9'h1A5);
    $display("forced parity test done");
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_plain();
    t_gen(8'h03);
    t_gen(8'h07);
    t_force(1'b1);
    t_force(1'b0);
    summarize();
  end
endmodule

// ===== hdl/psr_host_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - host changes address only while chip select or write enable is high.
// - device releases bus when write falls; host must not drive before.
// - host holds write data stable to the first rising strobe and a bit after.
// - host may write a wrong ninth bit unchecked, then read checked to test.
// - checked write then unchecked read returns generated parity as data.
// - unchecked write then checked read checks external parity; needs transceiver.
// - host may hold parity enable fixed or switch it between cycles.
module psr_host_ctrl #(
  parameter int ADDR_W = psr_pkg::ADDR_W,
  parameter int BYTE_W = psr_pkg::BYTE_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // user command side
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic              reqParity,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [BYTE_W:0]   reqData,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic [BYTE_W:0]        rspData,
  output logic                   rspParityFault,
  // memory pins
  output logic [ADDR_W-1:0]      word_address,
  output logic                   chipSel_b,
  output logic                   writeEn_b,
  output logic                   outEn_b,
  output logic                   parity_func_enable_n,
  input  wire logic [BYTE_W-1:0] byte_data_lines_i,
  output logic [BYTE_W-1:0]      byte_data_lines_o,
  output logic                   byte_data_lines_oe,
  input  wire logic              ninth_data_line_i,
  output logic                   ninth_data_line_o,
  output logic                   ninth_data_line_oe
);

  // ==========================================================
  // sequencer state
  psr_pkg::psr_state_t          state_ff, nxt_state;
  logic [psr_pkg::CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic                         isWr_ff, nxt_isWr;
  logic                         par_ff, nxt_par;
  logic [ADDR_W-1:0]            addr_ff, nxt_addr;
  logic [BYTE_W:0]              wdat_ff, nxt_wdat;
  logic                         ce_ff, nxt_ce;
  logic                         we_ff, nxt_we;
  logic                         oe_ff, nxt_oe;
  logic                         dOe_ff, nxt_dOe;
  logic                         nOe_ff, nxt_nOe;
  logic                         rdy_ff, nxt_rdy;
  logic                         rv_ff, nxt_rv;
  logic [BYTE_W:0]              rd_ff, nxt_rd;
  logic                         flt_ff, nxt_flt;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_isWr  = isWr_ff;
    nxt_par   = par_ff;
    nxt_addr  = addr_ff;
    nxt_wdat  = wdat_ff;
    nxt_ce    = ce_ff;
    nxt_we    = we_ff;
    nxt_oe    = oe_ff;
    nxt_dOe   = dOe_ff;
    nxt_nOe   = nOe_ff;
    nxt_rdy   = rdy_ff;
    nxt_rv    = 1'b0;
    nxt_rd    = rd_ff;
    nxt_flt   = flt_ff;
    case (state_ff)
      psr_pkg::PSR_IDLE:
      begin
        if (reqValid && rdy_ff)
        begin
          // address and parity mode change only while the chip is deselected
          nxt_addr  = reqAddr;
          nxt_wdat  = reqData;
          nxt_isWr  = reqWrite;
          nxt_par   = reqParity;
          nxt_rdy   = 1'b0;
          nxt_state = psr_pkg::PSR_SETUP;
        end
      end
      psr_pkg::PSR_SETUP:
      begin
        // pins now hold address; assert chip select
        nxt_ce = 1'b1;
        if (isWr_ff)
        begin
          // output enable stays high, so no contention when write falls
          nxt_we  = 1'b1;
          nxt_dOe = 1'b1;
          // ninth bit driven only for unchecked writes; checked writes generate it
          nxt_nOe = !par_ff;
          nxt_cnt = psr_pkg::CNT_W'(psr_pkg::WR_PULSE_CYC);
          nxt_state = psr_pkg::PSR_WR_PULSE;
        end
        else
        begin
          nxt_oe  = 1'b1;
          nxt_cnt = psr_pkg::CNT_W'(psr_pkg::RD_ACCESS_CYC);
          nxt_state = psr_pkg::PSR_RD_ACCESS;
        end
      end
      psr_pkg::PSR_WR_PULSE:
      begin
        nxt_cnt = cnt_ff - psr_pkg::CNT_ONE;
        if (cnt_ff == psr_pkg::CNT_ONE)
        begin
          // write enable ends the write; data and parity enable held past it
          nxt_we  = 1'b0;
          nxt_cnt = psr_pkg::CNT_W'(psr_pkg::HOLD_CYC);
          nxt_state = psr_pkg::PSR_WR_HOLD;
        end
      end
      psr_pkg::PSR_WR_HOLD:
      begin
        nxt_cnt = cnt_ff - psr_pkg::CNT_ONE;
        if (cnt_ff == psr_pkg::CNT_ONE)
        begin
          nxt_ce    = 1'b0;
          nxt_dOe   = 1'b0;
          nxt_nOe   = 1'b0;
          nxt_rv    = 1'b1;
          nxt_state = psr_pkg::PSR_RD_DONE;
        end
      end
      psr_pkg::PSR_RD_ACCESS:
      begin
        nxt_cnt = cnt_ff - psr_pkg::CNT_ONE;
        if (cnt_ff == psr_pkg::CNT_ONE)
        begin
          nxt_rd[BYTE_W-1:0] = byte_data_lines_i;
          // unchecked read: ninth bit is data, possibly stored parity
          nxt_rd[BYTE_W] = par_ff ? 1'b0 : ninth_data_line_i;
          // checked read: low on the shared line flags a parity fault
          nxt_flt = par_ff && !ninth_data_line_i;
          nxt_oe  = 1'b0;
          nxt_ce  = 1'b0;
          nxt_rv  = 1'b1;
          nxt_state = psr_pkg::PSR_RD_DONE;
        end
      end
      psr_pkg::PSR_RD_DONE:
      begin
        nxt_rdy   = 1'b1;
        nxt_state = psr_pkg::PSR_IDLE;
      end
      default:
      begin
        nxt_state = psr_pkg::PSR_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= psr_pkg::PSR_IDLE;
      cnt_ff   <= psr_pkg::CNT_ZERO;
      isWr_ff  <= 1'b0;
      par_ff   <= 1'b0;
      addr_ff  <= '0;
      wdat_ff  <= '0;
      ce_ff    <= 1'b0;
      we_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      dOe_ff   <= 1'b0;
      nOe_ff   <= 1'b0;
      rdy_ff   <= 1'b1;
      rv_ff    <= 1'b0;
      rd_ff    <= '0;
      flt_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      isWr_ff  <= nxt_isWr;
      par_ff   <= nxt_par;
      addr_ff  <= nxt_addr;
      wdat_ff  <= nxt_wdat;
      ce_ff    <= nxt_ce;
      we_ff    <= nxt_we;
      oe_ff    <= nxt_oe;
      dOe_ff   <= nxt_dOe;
      nOe_ff   <= nxt_nOe;
      rdy_ff   <= nxt_rdy;
      rv_ff    <= nxt_rv;
      rd_ff    <= nxt_rd;
      flt_ff   <= nxt_flt;
    end
  end

  // ==========================================================
  // pins, all straight from flip-flops
  assign word_address         = addr_ff;
  assign chipSel_b            = !ce_ff;
  assign writeEn_b            = !we_ff;
  assign outEn_b              = !oe_ff;
  assign parity_func_enable_n = !par_ff;
  assign byte_data_lines_o    = wdat_ff[BYTE_W-1:0];
  assign byte_data_lines_oe   = dOe_ff;
  assign ninth_data_line_o    = wdat_ff[BYTE_W];
  assign ninth_data_line_oe   = nOe_ff;
  assign reqReady             = rdy_ff;
  assign rspValid             = rv_ff;
  assign rspData              = rd_ff;
  assign rspParityFault       = flt_ff;

endmodule

// ===== hdl/psr_pkg.sv
package psr_pkg;
  // address and data widths of the parity memory
  localparam int ADDR_W = 13;
  localparam int BYTE_W = 8;
  // bus timing seen from the host, in ns as printed, and derived cycle counts
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ADDR_SETUP_NS    = 0;
  localparam int WRITE_PULSE_NS   = 60;
  localparam int ADDR_HOLD_NS     = 10;
  localparam int WE_HIZ_NS        = 30;
  localparam int READ_ACCESS_NS   = 45;
  localparam int WR_PULSE_CYC     = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_RAW     = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC         = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
  localparam int HIZ_CYC          = (WE_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_ACCESS_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  typedef enum logic [2:0] {
    PSR_IDLE,
    PSR_SETUP,
    PSR_WR_PULSE,
    PSR_WR_HOLD,
    PSR_RD_ACCESS,
    PSR_RD_DONE
  } psr_state_t;
endpackage
